// ---- pmtr_table_reader.sv ----
/*
  pmtr_table_reader: code store, fetch port and table-read path.
  assumes the core gives one-cycle instr_cycle_en pulses and holds
  its requests steady; programming pins come from outside the clock.
*/
// What this block does
// - 1024 by 14 bit code store
// - fetch starts at address zero after reset
// - table address comes from table pointer
// - low byte goes to named destination register
// - high part to latch, upper bits zero
// - last-page read addresses from page start
// - current-page read uses executing instruction's page
// - table read takes two instruction cycles, stalls
// - high latch read-only, changes on completion
// - programming data input only, oe held low; clock from programmer
// - debug data input only, never driven; debug clock input
// - debug pins double as programming pins
// - page is 256 words, upper bits select
`timescale 1ns/1ps
`default_nettype none
module pmtr_table_reader
  import pmtr_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        instr_cycle_en,
  input  wire logic [9:0]  pc_in,
  input  wire logic        read_table_current_page,
  input  wire logic        read_table_last_page,
  input  wire logic [7:0]  table_pointer,
  input  wire logic [6:0]  dest_addr_in,
  output logic [13:0]      instr_word,
  output logic [9:0]       fetch_addr,
  output logic             pipeline_stall,
  output logic             dest_we,
  output logic [6:0]       dest_addr,
  output logic [7:0]       dest_data,
  output logic [7:0]       table_high_latch,
  input  wire logic        debug_data_addr_line_in,
  output logic             debug_data_addr_line_out,
  output logic             debug_data_addr_line_oe,
  input  wire logic        debug_clock_in,
  output logic             prog_active
);
  // pc_in is the core's program counter; the core clears it to
  // PMTR_RESET_VEC on reset, we mirror it to fetch_addr.

  typedef struct packed {
    pmtr_state_t state;
    logic [9:0]  fetch_addr;
    logic [13:0] instr_word;
    logic [9:0]  tbl_addr;
    logic [6:0]  dest;
    logic        stall;
    logic        we;
    logic [7:0]  dest_data;
    logic [7:0]  hi;
    logic        pclk_prev;
    logic [3:0]  pbit;
    logic [13:0] pshift;
    logic [9:0]  paddr;
    logic        pwe;
    logic        sda_out;
    logic        sda_oe;
  } pmtr_regs_t;

  pmtr_regs_t r_q, r_d;

  logic [13:0] code_mem [PMTR_DEPTH];
  logic [13:0] rd_word;
  logic        sda_s;
  logic        sck_s;

  // debug pins double as programming pins: one port pair serves both
  pmtr_sync u_sync_sda (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .pin_in   (debug_data_addr_line_in),
    .pin_sync (sda_s)
  );
  pmtr_sync u_sync_sck (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .pin_in   (debug_clock_in),
    .pin_sync (sck_s)
  );

  // single read port shared by fetch and table read; the stall cycle
  // is what buys the table its own access slot
  always_ff @(posedge clk_sys) begin
    if (r_q.pwe) begin
      code_mem[r_q.paddr] <= r_q.pshift;
    end
    // table address held until the completing cycle has its word
    rd_word <= code_mem[r_d.state != PMTR_IDLE ? r_d.tbl_addr
                                               : r_d.fetch_addr];
  end

  always_comb begin
    r_d           = r_q;
    r_d.we        = 1'b0;
    r_d.pwe       = 1'b0;
    r_d.pclk_prev = sck_s;
    r_d.fetch_addr = pc_in;
    if (r_q.pwe) begin
      r_d.paddr = r_q.paddr + 10'h001;
    end
    unique case (r_q.state)
      PMTR_IDLE: begin
        r_d.instr_word = rd_word;
        if (instr_cycle_en &&
            (read_table_current_page || read_table_last_page)) begin
          // page bits on top, pointer byte below
          r_d.tbl_addr = {read_table_last_page ? PMTR_LAST_PAGE
                                               : pc_in[9:8],
                          table_pointer};
          r_d.dest  = dest_addr_in;
          r_d.stall = 1'b1;
          r_d.state = PMTR_STALL;
        end
      end
      PMTR_STALL: begin
        if (instr_cycle_en) begin
          r_d.state = PMTR_DONE; // second instruction cycle
        end
      end
      PMTR_DONE: begin
        r_d.dest_data = rd_word[7:0];
        r_d.hi = {2'b00, rd_word[13:8]};
        r_d.we    = 1'b1;
        r_d.stall = 1'b0;
        r_d.state = PMTR_IDLE;
      end
    endcase
    // programming: shift one data bit per rising programmer clock.
    // framing beyond bit capture is not defined, so a word is 14 bits
    // msb first, written at paddr, then the address advances.
    if (sck_s && !r_q.pclk_prev) begin
      r_d.pshift = {r_q.pshift[12:0], sda_s};
      if (r_q.pbit == PMTR_PROG_BITS) begin
        r_d.pbit = 4'h0;
        r_d.pwe  = 1'b1;
      end else begin
        r_d.pbit = r_q.pbit + 4'h1;
      end
    end
    r_d.sda_out = rd_word[13];
    r_d.sda_oe  = 1'b0; // host owns the line until a readback scheme exists
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      r_q            <= '0;
      r_q.state      <= PMTR_IDLE;
      r_q.fetch_addr <= PMTR_RESET_VEC;
      r_q.hi         <= PMTR_HI_RST;
      r_q.dest_data  <= PMTR_TBL_RST;
    end else begin
      r_q <= r_d;
    end
  end

  assign instr_word               = r_q.instr_word;
  assign fetch_addr               = r_q.fetch_addr;
  assign pipeline_stall           = r_q.stall;
  assign dest_we                  = r_q.we;
  assign dest_addr                = r_q.dest;
  assign dest_data                = r_q.dest_data;
  assign table_high_latch         = r_q.hi;
  assign debug_data_addr_line_out = r_q.sda_out;
  assign debug_data_addr_line_oe  = r_q.sda_oe;
  assign prog_active              = r_q.pclk_prev;
endmodule : pmtr_table_reader
`default_nettype wire

// ---- pmtr_pkg.sv ----
/*
  pmtr_pkg: constants and types for the program memory table reader.
  assumes one 125 MHz clock and a synchronous active-high reset.
*/
package pmtr_pkg;
  localparam int unsigned PMTR_WORD_W   = 14;
  localparam int unsigned PMTR_DEPTH    = 1024;
  localparam int unsigned PMTR_ADDR_W   = 10;
  localparam int unsigned PMTR_PAGE_W   = 2;
  localparam int unsigned PMTR_LOW_W    = 8;
  localparam int unsigned PMTR_HIGH_W   = 6;
  localparam logic [9:0] PMTR_RESET_VEC = 10'h000;
  localparam logic [1:0] PMTR_LAST_PAGE = 2'h3;
  localparam logic [7:0] PMTR_TBL_RST   = 8'h00;
  localparam logic [7:0] PMTR_HI_RST    = 8'h00;
  // last bit index of one 14-bit programming word
  localparam logic [3:0] PMTR_PROG_BITS = 4'hd;

  typedef enum logic [1:0] {
    PMTR_IDLE,
    PMTR_STALL,
    PMTR_DONE
  } pmtr_state_t;
endpackage : pmtr_pkg

// ---- pmtr_sync.sv ----
/*
  pmtr_sync: two-flop synchroniser for a pin level.
  assumes the input is asynchronous to clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module pmtr_sync (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic pin_in,
  output logic      pin_sync
);
  logic meta_q;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta_q   <= 1'b0;
      pin_sync <= 1'b0;
    end else begin
      meta_q   <= pin_in;
      pin_sync <= meta_q;
    end
  end
endmodule : pmtr_sync
`default_nettype wire

// ---- pmtr_sva.sv ----
/* pmtr_sva: port checks for the table reader.
   assumes one clk_sys domain and sync active-high rst. */
`timescale 1ns/1ps
`default_nettype none
module pmtr_sva (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       instr_cycle_en,
  input wire logic       read_table_current_page,
  input wire logic       read_table_last_page,
  input wire logic       pipeline_stall,
  input wire logic       dest_we,
  input wire logic [7:0] dest_data,
  input wire logic [7:0] table_high_latch,
  input wire logic [9:0] fetch_addr
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire req = instr_cycle_en & (read_table_current_page | read_table_last_page);
  hi_zero_a: assert property (table_high_latch[7:6] == 2'h0)
    else $error("latch top bits set");
  we_pulse_a: assert property (dest_we |=> !dest_we)
    else $error("write pulse too long");
  we_unstall_a: assert property (dest_we |-> !pipeline_stall)
    else $error("stall left at completion");
  req_stall_a: assert property (req && !pipeline_stall && !dest_we
    |=> pipeline_stall) else $error("request did not stall");
  stall_done_a: assert property (pipeline_stall && instr_cycle_en
    |-> ##2 dest_we) else $error("no completion after second cycle");
  hi_hold_a: assert property (!$past(rst) &&
    $changed(table_high_latch) |-> dest_we)
    else $error("latch moved outside completion");
  data_hold_a: assert property (!$past(rst) &&
    $changed(dest_data) |-> dest_we)
    else $error("data moved outside completion");
  vec_zero_a: assert property (disable iff (1'b0) rst
    |=> fetch_addr == 10'h000) else $error("fetch not at zero");
  cover property (req && read_table_last_page);
  cover property (req && read_table_current_page);
  cover property (dest_we);
endmodule : pmtr_sva
bind pmtr_table_reader pmtr_sva pmtr_sva_inst (.clk_sys, .rst,
  .instr_cycle_en, .read_table_current_page, .read_table_last_page,
  .pipeline_stall, .dest_we, .dest_data, .table_high_latch, .fetch_addr);
`default_nettype wire

// ---- pmtr_core_model.sv ----
/* pmtr_core_model: core pacing, one enable per four clocks.
   assumes clk_sys and sync rst shared with the reader. */
`timescale 1ns/1ps
`default_nettype none
module pmtr_core_model (
  input  wire logic clk_sys,
  input  wire logic rst,
  output logic      instr_cycle_en
);
  logic [1:0] phase_q;
  // four clock phases form one instruction cycle
  always_ff @(posedge clk_sys) begin
    phase_q        <= rst ? 2'h0 : phase_q + 2'h1;
    instr_cycle_en <= !rst && (phase_q == 2'h3);
  end
endmodule : pmtr_core_model
`default_nettype wire

// ---- test_program_memory_table_reader.sv ----
/* test_program_memory_table_reader: random table reads.
   assumes the core model paces instruction cycles by four. */
`timescale 1ns/1ps
`default_nettype none
module test_program_memory_table_reader;
  logic        clk_sys = 1'b0, rst = 1'b1, cur = 1'b0, last = 1'b0, dck = 1'b0;
  logic        pdi = 1'b0;
  logic        en, stall, we, oe, pdo, pact;
  logic [9:0]  pc = 10'h000, fa;
  logic [7:0]  ptr = 8'h00, dd, hi;
  logic [6:0]  dst = 7'h00, da;
  logic [13:0] iw;
  int          error_cnt = 0, num_checks = 0, n;
  always #4 clk_sys = ~clk_sys;
  pmtr_core_model pmtr_core_model_inst (.clk_sys, .rst, .instr_cycle_en(en));
  pmtr_table_reader pmtr_table_reader_inst (.clk_sys, .rst,
    .instr_cycle_en(en), .pc_in(pc), .read_table_current_page(cur),
    .read_table_last_page(last), .table_pointer(ptr), .dest_addr_in(dst),
    .instr_word(iw), .fetch_addr(fa), .pipeline_stall(stall), .dest_we(we),
    .dest_addr(da), .dest_data(dd), .table_high_latch(hi),
    .debug_data_addr_line_in(pdi), .debug_data_addr_line_out(pdo),
    .debug_data_addr_line_oe(oe), .debug_clock_in(dck), .prog_active(pact));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_of_test;
    if (error_cnt == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  // completion lands one clock after the next enable, four clocks apart
  // seen at the edge after the write pulse is launched
  function automatic int exp_lat();
    return 6;
  endfunction : exp_lat
  // code word the bench programs at each address
  function automatic logic [13:0] word_of(input logic [9:0] a);
    return {a, 4'h0} ^ {4'h0, a} ^ 14'h2c93;
  endfunction : word_of
  task automatic prog_word(input logic [13:0] w);
    for (int b = 13; b >= 0; b--) begin
      pdi <= w[b]; dck <= 1'b0;
      repeat (2) @(posedge clk_sys);
      dck <= 1'b1;
      repeat (2) @(posedge clk_sys);
    end
  endtask : prog_word
  task automatic tbl_read(input logic lp, input logic [7:0] p,
                          input logic [6:0] d);
    logic [13:0] w;
    cur <= !lp; last <= lp; ptr <= p; dst <= d;
    do @(posedge clk_sys); while (en !== 1'b1);
    w = word_of({lp ? 2'b11 : pc[9:8], p});
    // released pointer and destination show the inverse so stale values cannot pass
    cur <= 1'b0; last <= 1'b0; ptr <= ~p; dst <= ~d;
    n = 0;
    do begin @(posedge clk_sys); n++; end while (we !== 1'b1 && n < 20);
    chk(16'(n), 16'(exp_lat()));
    chk(16'(da), 16'(d));
    chk(16'(dd), 16'(w[7:0]));
    chk(16'(hi), 16'({2'b00, w[13:8]}));
    chk(16'(hi[7:6]), 16'h0000);
    chk(16'(stall), 16'h0000);
  endtask : tbl_read
  initial begin
    n = int'($urandom(32'hfbdd_e409));
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    chk(16'(fa), 16'h0000);
    for (int a = 0; a < 1024; a++) prog_word(word_of(10'(a)));
    repeat (8) @(posedge clk_sys);
    chk(16'(oe), 16'h0000);
    tbl_read(1'b1, 8'h06, 7'h40);
    tbl_read(1'b0, 8'hff, 7'h7f);
    repeat (40) begin
      pc <= 10'($urandom);
      tbl_read(1'($urandom), 8'($urandom), 7'($urandom));
    end
    dck <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk(16'(pact), 16'h0001);
    rst <= 1'b1; pc <= 10'h000;
    @(posedge clk_sys); rst <= 1'b0;
    @(posedge clk_sys);
    chk(16'(fa), 16'h0000);
    pc <= 10'h123;
    repeat (4) @(posedge clk_sys);
    chk(16'(iw), 16'(word_of(10'h123)));
    end_of_test();
  end
  initial begin
    #(8 * 75000);
    error_cnt++;
    end_of_test();
  end
endmodule : test_program_memory_table_reader
`default_nettype wire
